/* i2c_target_cfg.svh */
`ifndef I2C_TARGET_CFG_SVH
`define I2C_TARGET_CFG_SVH
`define TGT_ADDR 7'h17
`define BIT_MSB 3'h7
`define PTR_RESET 8'h00
`endif

/* i2c_target_pkg.sv */
package i2c_target_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110
  } bus_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic valid;
  } reg_wr_t;
endpackage

/* i2c_register_target_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2c_target_cfg.svh"
module i2c_register_target_port (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Register bank side
  output i2c_target_pkg::reg_wr_t reg_wr_out,
  output logic [7:0] reg_ptr_out,
  input wire logic [7:0] reg_rd_data_in,
  output logic busy_out
);
  import i2c_target_pkg::*;

  logic [2:0] scl_sync_q, sda_sync_q;
  logic scl_q, sda_q;
  bus_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic ptr_set_q;
  logic rd_q;
  logic nack_q;
  logic sda_oe_q;
  reg_wr_t wr_q;
  logic busy_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  wire scl_agree = scl_sync_q[1] == scl_sync_q[2];
  wire sda_agree = sda_sync_q[1] == sda_sync_q[2];
  wire scl_f = scl_agree ? scl_sync_q[2] : scl_q;
  wire sda_f = sda_agree ? sda_sync_q[2] : sda_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise = scl_f && !scl_q;
  wire scl_fall = !scl_f && scl_q;
  wire start_det = scl_f && scl_q && sda_q && !sda_f;
  wire stop_det = scl_f && scl_q && !sda_q && sda_f;
  wire [7:0] rx_byte = {shift_q[6:0], sda_f};
  wire last_bit = bit_q == 3'h0;
  wire addr_hit = rx_byte[7:1] == `TGT_ADDR;
  wire [7:0] ptr_inc = ptr_q + 8'h01;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      bit_q <= `BIT_MSB;
      shift_q <= 8'h00;
      ptr_q <= `PTR_RESET;
      ptr_set_q <= 1'b0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      wr_q.valid <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        bit_q <= `BIT_MSB;
        sda_oe_q <= 1'b0;
        nack_q <= 1'b0;
        busy_q <= 1'b1;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        busy_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q <= bit_q - 3'h1;
              if (last_bit && state_q == ST_ADDR) begin
                rd_q <= rx_byte[0];
                ptr_set_q <= 1'b0;
                state_q <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
              end else if (last_bit) begin
                if (!ptr_set_q) begin
                  ptr_q <= rx_byte;
                  ptr_set_q <= 1'b1;
                end else begin
                  wr_q.addr <= ptr_q;
                  wr_q.data <= rx_byte;
                  wr_q.valid <= 1'b1;
                  ptr_q <= ptr_inc;
                end
                state_q <= ST_WR_ACK;
              end
            end
            if (scl_fall && bit_q == 3'h7 && state_q != ST_ADDR) begin
              sda_oe_q <= 1'b0;
            end
          end
          ST_ADDR_ACK, ST_WR_ACK: begin
            if (scl_fall && !sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else if (scl_fall) begin
              bit_q <= `BIT_MSB;
              if (state_q == ST_ADDR_ACK && rd_q) begin
                shift_q <= reg_rd_data_in;
                sda_oe_q <= !reg_rd_data_in[7];
                state_q <= ST_RD;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (last_bit) begin
                sda_oe_q <= 1'b0;
                state_q <= ST_RD_ACK;
                ptr_q <= ptr_inc;
              end else begin
                bit_q <= bit_q - 3'h1;
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_q <= !shift_q[6];
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              nack_q <= sda_f;
            end
            if (scl_fall) begin
              bit_q <= `BIT_MSB;
              if (nack_q) begin
                sda_oe_q <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                shift_q <= reg_rd_data_in;
                sda_oe_q <= !reg_rd_data_in[7];
                state_q <= ST_RD;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_q;
  assign reg_wr_out = wr_q;
  assign reg_ptr_out = ptr_q;
  assign busy_out = busy_q;

  property p_stop_releases;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      stop_det |=> !sda_oe_q && state_q == ST_IDLE;
  endproperty
  a_stop_releases: assert property (p_stop_releases)
    else $error("SDA held after STOP");

  property p_start_addr;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      start_det |=> state_q == ST_ADDR && bit_q == 3'h7;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("START did not restart address");

  property p_sda_change_low;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      scl_q && scl_f && !start_det && !stop_det |=> $stable(sda_oe_q);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low)
    else $error("SDA changed while SCL high");

  property p_miss_addr;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_ADDR && scl_rise && last_bit && !addr_hit
      && !start_det && !stop_det |=> state_q == ST_IDLE;
  endproperty
  a_miss_addr: assert property (p_miss_addr)
    else $error("Foreign address accepted");

  property p_wr_inc;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      wr_q.valid |-> ptr_q == wr_q.addr + 8'h01;
  endproperty
  a_wr_inc: assert property (p_wr_inc)
    else $error("Pointer not incremented");

  property p_nack_release;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_RD_ACK && nack_q && scl_fall && !start_det && !stop_det
      |=> !sda_oe_q [*2];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("SDA driven after NACK");

  property p_idle_free;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_IDLE |-> !sda_oe_q;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("SDA driven while idle");

  property p_ack_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_WR_ACK && sda_oe_q && scl_rise |=> sda_oe_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Acknowledge not held");

  property p_rd_msb;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_RD |-> sda_oe_q == !shift_q[7];
  endproperty
  a_rd_msb: assert property (p_rd_msb)
    else $error("Read bit not taken from the top of the byte");

  property p_rd_inc;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_RD && scl_fall && last_bit && !start_det && !stop_det
      |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_rd_inc: assert property (p_rd_inc)
    else $error("Pointer not advanced after read byte");

  property p_ptr_only;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_WR && scl_rise && last_bit && !ptr_set_q
      && !start_det && !stop_det |=> ptr_set_q && !wr_q.valid;
  endproperty
  a_ptr_only: assert property (p_ptr_only)
    else $error("Pointer byte treated as data");

  property p_valid_pulse;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      wr_q.valid |=> !wr_q.valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("Write strobe longer than one cycle");

  c_write: cover property (@(posedge sys_clk_in) wr_q.valid);
  c_read: cover property (@(posedge sys_clk_in) state_q == ST_RD_ACK);
  c_nack: cover property (@(posedge sys_clk_in) nack_q && scl_fall);
  c_restart: cover property (@(posedge sys_clk_in) start_det && busy_q);
endmodule
`default_nettype wire

/* i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start();
    // Give the target time to drop its acknowledge before SCL rises
    q(2);
    sda_out = 1'b1;
    q(2);
    scl_out = 1'b1;
    q(2);
    sda_out = 1'b0;
    q(2);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    // SDA falls well inside the SCL low phase, then rises while SCL is high
    q(2);
    sda_out = 1'b0;
    q(2);
    scl_out = 1'b1;
    q(2);
    sda_out = 1'b1;
    q(4);
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      q(2);
      sda_out = tx[i];
      q(2);
      scl_out = 1'b1;
      q(2);
      rx[i] = sda_in;
      q(2);
      scl_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* i2c_register_target_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_register_target_port_tb_top;
  import i2c_target_pkg::*;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic scl, m_sda, oe, sda_o, busy;
  logic [7:0] ptr, d;
  logic [8:0] rx;
  logic [15:0] exp_q[$];
  reg_wr_t wr;
  int n_fail = 0, num_checks = 0, seed = 78;
  wire logic sda;
  // Open-drain wire with pull-up
  assign sda = oe ? (m_sda & sda_o) : m_sda;
  initial forever #20 sys_clk_in = ~sys_clk_in;
  i2c_master_model i_master (.clk_in(sys_clk_in), .sda_in(sda),
    .scl_out(scl), .sda_out(m_sda));
  i2c_register_target_port i_dut (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(oe), .reg_wr_out(wr), .reg_ptr_out(ptr),
    .reg_rd_data_in(ptr ^ 8'h5a), .busy_out(busy));
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr_byte(input logic [7:0] b, input logic ack_exp);
    i_master.xfer({b, 1'b1}, rx);
    chk("ack", 16'(ack_exp), 16'(rx[0]));
  endtask
  task automatic rd_byte(input logic [7:0] e, input logic last);
    i_master.xfer({8'hff, last}, rx);
    chk("read", 16'(e), 16'(rx[8:1]));
  endtask
  // Every written byte must have been announced
  always @(negedge sys_clk_in) if (wr.valid === 1'b1) begin
    chk("write", exp_q.size() ? exp_q.pop_front() : 16'hxxxx,
        {wr.addr, wr.data});
  end
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    // Burst write across the pointer wrap
    i_master.start();
    wr_byte(8'h2e, 1'b0);
    chk("busy", 16'h1, 16'(busy));
    wr_byte(8'hff, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      exp_q.push_back({8'(8'hff + i), d});
      wr_byte(d, 1'b0);
    end
    i_master.stop();
    repeat (4) @(negedge sys_clk_in);
    chk("busy", 16'h0, 16'(busy));
    chk("pending", 16'h0, 16'(exp_q.size()));
    // Foreign address is ignored
    i_master.start();
    wr_byte(8'h2c, 1'b1);
    wr_byte(8'h10, 1'b1);
    i_master.stop();
    // Pointer only, then repeated start and read
    i_master.start();
    wr_byte(8'h2e, 1'b0);
    wr_byte(8'h40, 1'b0);
    i_master.start();
    wr_byte(8'h2f, 1'b0);
    for (int i = 0; i < 3; i++) rd_byte(8'(8'h40 + i) ^ 8'h5a, i == 2);
    chk("ptr", 16'h43, 16'(ptr));
    rd_byte(8'hff, 1'b1);
    chk("busy", 16'h1, 16'(busy));
    i_master.stop();
    repeat (8) @(negedge sys_clk_in);
    chk("busy", 16'h0, 16'(busy));
    give_verdict();
  end
endmodule
`default_nettype wire
